/* hdl/rmp_phy_side.sv */
`timescale 1ns/1ps
`include "rmp_defines.svh"
module rmp_phy_side
  import rmp_pkg::*;
#(
  parameter bit VARIANT_GEN_CLK = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_clock_in,
  input  wire logic        ref_clk_i,
  output logic             ref_clk_o,
  output logic             ref_clk_oe,
  input  wire logic        txen,
  input  wire logic        txd0,
  input  wire logic        txd1_i,
  output logic             txd1_o,
  output logic             txd1_oe,
  input  wire logic        crs_dv_i,
  output logic             crs_dv_o,
  output logic             crs_dv_oe,
  output logic      [1:0]  rxd_o,
  output logic             rxd_oe,
  input  wire logic        rxer_i,
  output logic             rxer_o,
  output logic             rxer_oe,
  output logic             irq_open_drain_out_o,
  output logic             irq_open_drain_out_oe,
  input  wire logic        rx_vld,
  input  wire logic        rx_err,
  input  wire logic [1:0]  rx_dat,
  output logic             rx_take,
  output logic             tx_vld,
  output logic      [1:0]  tx_dat,
  output logic      [4:0]  mgmt_addr
);

  rmp_pins_t  pin_raw;
  rmp_pins_t  s1_q;
  rmp_pins_t  s2_q;
  rmp_phase_t phase_q;
  logic [1:0] strap_cnt_q;
  logic       rxer_strap_q;
  logic       clk_sel_q;
  logic       rxer_ovr_q;
  logic       osc_prev_q;
  logic [2:0] div_q;
  logic       gen_q;
  logic       ref_edge;
  logic       nand_mode;
  logic       txen_prev_q;
  logic       crs_prev_q;
  logic       ap_go;
  logic       ap_wr;
  logic [9:0] ap_idx;
  logic [`RMP_IRQ_W-1:0] stat_q;
  logic [`RMP_IRQ_W-1:0] mask_q;
  logic [`RMP_IRQ_W-1:0] ev;

  // Register index from a byte address; unaligned bits dropped
  function automatic logic [9:0] word_idx(input logic [11:0] a);
    return a[11:2];
  endfunction : word_idx

  // Two-flop synchroniser on every pin from the MAC side
  assign pin_raw = '{txen: txen, txd: {txd1_i, txd0}, osc: osc_clock_in, crs: crs_dv_i, rxer: rxer_i};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  // Pins stay inputs until the synchroniser holds the released-reset level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q     <= PH_STRAP;
      strap_cnt_q <= 2'h0;
    end else begin
      unique case (phase_q)
        PH_STRAP: begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
          if (strap_cnt_q == 2'(`RMP_STRAP_CYC - 1)) begin
            phase_q <= PH_RUN;
          end
        end
        PH_RUN: begin
          phase_q <= PH_RUN;
        end
      endcase
    end
  end

  // Straps caught from synchronised pins at the end of the strap window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_addr    <= `RMP_ADDR_LOW;
      rxer_strap_q <= 1'b0;
    end else if (phase_q == PH_STRAP && strap_cnt_q == 2'(`RMP_STRAP_CYC - 1)) begin
      mgmt_addr    <= s2_q.crs ? `RMP_ADDR_HIGH : `RMP_ADDR_LOW;
      rxer_strap_q <= s2_q.rxer;
    end
  end

  // A high error strap means NAND-tree test until software overrides it
  assign nand_mode = rxer_strap_q & ~rxer_ovr_q;

  // Reference clock generator; the pclk rate limits it to a slow stand-in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
      gen_q <= 1'b0;
    end else if (div_q == 3'(`RMP_REF_HALF_CYC - 1)) begin
      div_q <= 3'h0;
      gen_q <= ~gen_q;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // Rising edge of whichever clock the mode selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= s2_q.osc;
    end
  end
  assign ref_edge = clk_sel_q ? (div_q == 3'(`RMP_REF_HALF_CYC - 1) && !gen_q)
                              : (s2_q.osc && !osc_prev_q);

  // Clock pin driven only in generate mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clk_o  <= 1'b0;
      ref_clk_oe <= 1'b0;
    end else begin
      ref_clk_o  <= clk_sel_q & gen_q;
      ref_clk_oe <= clk_sel_q & (phase_q == PH_RUN);
    end
  end

  // Receive dibits launched once per reference period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_dv_o <= 1'b0;
      rxd_o    <= 2'h0;
      rxer_o   <= 1'b0;
      rx_take  <= 1'b0;
    end else begin
      rx_take <= ref_edge && phase_q == PH_RUN;
      if (ref_edge && phase_q == PH_RUN) begin
        crs_dv_o <= rx_vld;
        rxd_o    <= rx_vld ? rx_dat : 2'h0;
        rxer_o   <= rx_vld & rx_err;
      end
    end
  end

  // Strap pins become outputs after the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_dv_oe <= 1'b0;
      rxd_oe    <= 1'b0;
      rxer_oe   <= 1'b0;
    end else begin
      crs_dv_oe <= phase_q == PH_RUN;
      rxd_oe    <= phase_q == PH_RUN;
      rxer_oe   <= phase_q == PH_RUN;
    end
  end

  // Transmit dibits sampled once per reference period, refused in test mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_vld <= 1'b0;
      tx_dat <= 2'h0;
    end else begin
      tx_vld <= ref_edge && s2_q.txen && !nand_mode && phase_q == PH_RUN;
      if (ref_edge && s2_q.txen && !nand_mode) begin
        tx_dat <= s2_q.txd;
      end
    end
  end

  // NAND tree over transmit enable, lower transmit bit, oscillator and carrier pins; the upper transmit pin carries it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd1_o  <= 1'b0;
      txd1_oe <= 1'b0;
    end else begin
      txd1_o  <= ~&{s2_q.txen, s2_q.txd[0], s2_q.osc, s2_q.crs};
      txd1_oe <= nand_mode && phase_q == PH_RUN;
    end
  end

  // Frame boundary and receive error events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_prev_q <= 1'b0;
      crs_prev_q  <= 1'b0;
    end else if (ref_edge) begin
      txen_prev_q <= s2_q.txen;
      crs_prev_q  <= rx_vld;
    end
  end
  always_comb begin
    ev = '0;
    ev[`RMP_IRQ_RX_START] = ref_edge & rx_vld & ~crs_prev_q;
    ev[`RMP_IRQ_TX_START] = ref_edge & s2_q.txen & ~txen_prev_q;
    ev[`RMP_IRQ_RX_ERR]   = ref_edge & rx_vld & rx_err;
    ev[`RMP_IRQ_TX_END]   = ref_edge & ~s2_q.txen & txen_prev_q;
  end

  // APB decode: one wait state, so every answer comes from a flop
  assign ap_idx = word_idx(paddr);
  assign ap_go  = psel & penable & pready;
  assign ap_wr  = ap_go & pwrite;

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else if (ap_wr && ap_idx == 10'(`RMP_IDX_IRQ_STAT)) begin
      stat_q <= (stat_q & ~pwdata[`RMP_IRQ_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Control registers; clock mode resets to the variant default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q     <= '0;
      clk_sel_q  <= VARIANT_GEN_CLK;
      rxer_ovr_q <= 1'b0;
    end else if (ap_wr) begin
      if (ap_idx == 10'(`RMP_IDX_IRQ_MASK)) begin
        mask_q <= pwdata[`RMP_IRQ_W-1:0];
      end
      if (ap_idx == 10'(`RMP_IDX_CLK_CTL)) begin
        clk_sel_q <= pwdata[`RMP_BIT_CLK_SEL];
      end
      if (ap_idx == 10'(`RMP_IDX_RXER_CTL)) begin
        rxer_ovr_q <= pwdata[`RMP_BIT_RXER_OVR];
      end
    end
  end

  // Access phase: answer one cycle after penable rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (ap_idx)
        10'(`RMP_IDX_IRQ_STAT): prdata[`RMP_IRQ_W-1:0] <= stat_q;
        10'(`RMP_IDX_IRQ_MASK): prdata[`RMP_IRQ_W-1:0] <= mask_q;
        10'(`RMP_IDX_STRAP):    prdata[7:0] <= {nand_mode, rxer_strap_q, 1'b0, mgmt_addr};
        10'(`RMP_IDX_CLK_CTL):  prdata[`RMP_BIT_CLK_SEL] <= clk_sel_q;
        10'(`RMP_IDX_RXER_CTL): prdata[`RMP_BIT_RXER_OVR] <= rxer_ovr_q;
        default:                pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Open-drain interrupt: output fixed low, enable pulls the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_open_drain_out_o  <= 1'b0;
      irq_open_drain_out_oe <= 1'b0;
    end else begin
      irq_open_drain_out_o  <= 1'b0;
      irq_open_drain_out_oe <= |(stat_q & mask_q);
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence edge_rx_s;
    ref_edge && phase_q == PH_RUN && rx_vld;
  endsequence
  sequence edge_tx_s;
    ref_edge && phase_q == PH_RUN && s2_q.txen && !nand_mode;
  endsequence

  rx_dibit_out_a: assert property (edge_rx_s |=> crs_dv_o && rxd_o == $past(rx_dat))
    else $error("receive dibit not launched");
  crs_idle_a: assert property (ref_edge && phase_q == PH_RUN && !rx_vld |=> !crs_dv_o && rxd_o == 2'h0)
    else $error("carrier sense not dropped");
  tx_dibit_in_a: assert property (edge_tx_s |=> tx_vld && tx_dat == $past(s2_q.txd))
    else $error("transmit dibit not taken");
  tx_quiet_a: assert property (tx_vld |-> $past(ref_edge) && !$past(nand_mode))
    else $error("transmit taken off the reference edge");
  strap_addr_a: assert property ($rose(phase_q == PH_RUN) |=> mgmt_addr[4:2] == 3'h0
                                 && mgmt_addr[1] == mgmt_addr[0])
    else $error("strap address malformed");
  strap_oe_a: assert property (phase_q == PH_STRAP |=> !crs_dv_oe && !rxer_oe)
    else $error("strap pin driven during strap window");
  pins_driven_a: assert property (phase_q == PH_RUN ##1 phase_q == PH_RUN |-> crs_dv_oe && rxd_oe)
    else $error("pins not driven after strap window");
  ref_gen_a: assert property (!clk_sel_q ##1 !clk_sel_q |-> !ref_clk_oe)
    else $error("reference pin driven in input mode");
  ref_drive_a: assert property (clk_sel_q && phase_q == PH_RUN ##1 clk_sel_q |-> ref_clk_oe)
    else $error("reference clock not driven");
  rxer_qual_a: assert property (rxer_o |-> crs_dv_o)
    else $error("receive error without data valid");
  nand_pin_a: assert property (nand_mode && phase_q == PH_RUN |=> txd1_oe && !tx_vld)
    else $error("NAND-tree pin not driven");
  irq_od_a: assert property (|(stat_q & mask_q) |=> irq_open_drain_out_oe && !irq_open_drain_out_o)
    else $error("interrupt not pulled low");
  clk_sel_wr_a: assert property (ap_wr && ap_idx == 10'(`RMP_IDX_CLK_CTL)
                                 |=> clk_sel_q == $past(pwdata[`RMP_BIT_CLK_SEL]))
    else $error("clock select write lost");

endmodule : rmp_phy_side

/* hdl/rmp_defines.svh */
`ifndef RMP_DEFINES_SVH
`define RMP_DEFINES_SVH
// Register indexes; byte address is four times the index
`define RMP_IDX_IRQ_STAT   8'h00
`define RMP_IDX_IRQ_MASK   8'h01
`define RMP_IDX_STRAP      8'h02
`define RMP_IDX_RXER_CTL   8'h16
`define RMP_IDX_CLK_CTL    8'h1F
// Field positions
`define RMP_BIT_CLK_SEL    7
`define RMP_BIT_RXER_OVR   15
`define RMP_IRQ_W          4
`define RMP_IRQ_RX_START   0
`define RMP_IRQ_TX_START   1
`define RMP_IRQ_RX_ERR     2
`define RMP_IRQ_TX_END     3
// Strap values of the management address
`define RMP_ADDR_HIGH      5'h03
`define RMP_ADDR_LOW       5'h00
// Timing
`define RMP_PCLK_NS        50
`define RMP_REF_HALF_NS    200
`define RMP_REF_HALF_CYC   ((`RMP_REF_HALF_NS + `RMP_PCLK_NS - 1) / `RMP_PCLK_NS)
`define RMP_STRAP_CYC      3
`endif

/* hdl/rmp_pkg.sv */
package rmp_pkg;
  // Pins sampled from the MAC side
  typedef struct packed {
    logic       txen;
    logic [1:0] txd;
    logic       osc;
    logic       crs;
    logic       rxer;
  } rmp_pins_t;

  // One receive dibit with its qualifiers
  typedef struct packed {
    logic       vld;
    logic       err;
    logic [1:0] dat;
  } rmp_dibit_t;

  typedef enum logic {PH_STRAP, PH_RUN} rmp_phase_t;
endpackage : rmp_pkg

/* verification/rmp_mac_model.sv */
`timescale 1ns/1ps
// MAC transmit side; launches its dibits on the shared reference rising edge
module rmp_mac_model (
  input  wire logic       ref_clk,
  input  wire logic       send,
  input  wire logic [1:0] dat,
  input  wire logic       pull_hi,
  output logic            txen,
  output logic      [1:0] txd,
  output logic            rxer_pull
);
  // Enable marks only periods that carry a real dibit; data parked at 00 otherwise
  always @(posedge ref_clk) begin
    txen <= send;
    txd  <= send ? dat : 2'h0;
  end

  // Error pin left on its pull-down unless a high strap is asked for
  assign rxer_pull = pull_hi;
endmodule : rmp_mac_model

/* verification/tb_rmii_phy_side.sv */
`timescale 1ns/1ps
`include "rmp_defines.svh"
module tb_rmii_phy_side_interface;
  import rmp_pkg::*;
  localparam logic [11:0] A_STAT  = 12'(`RMP_IDX_IRQ_STAT) * 12'h004;
  localparam logic [11:0] A_MASK  = 12'(`RMP_IDX_IRQ_MASK) * 12'h004;
  localparam logic [11:0] A_STRAP = 12'(`RMP_IDX_STRAP) * 12'h004;
  localparam logic [11:0] A_RXER  = 12'(`RMP_IDX_RXER_CTL) * 12'h004;
  localparam logic [11:0] A_CLK   = 12'(`RMP_IDX_CLK_CTL) * 12'h004;
  logic        pclk, presetn, psel, penable, pwrite, osc, send, nand_req, crs_pull, rx_vld, rx_err, er;
  logic        pready, pslverr, ref_clk_o, ref_clk_oe, txen, txd1_o, txd1_oe, crs_dv_o, crs_dv_oe, rxd_oe;
  logic        rxer_o, rxer_oe, irq_open_drain_out_o, irq_open_drain_out_oe, rx_take, tx_vld, rxer_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mdat, rx_dat, rxd_o, tx_dat, txd;
  logic [4:0]  mgmt_addr;
  wire         ref_w, crs_w, rxer_w, t1_w, irq_w;
  int          fail_count, checks_done, n;

  // Clocks: system 50 ns, link oscillator 400 ns, unrelated phase
  always #25 pclk = ~pclk;
  always #200 osc = ~osc;

  // Wire levels of the shared pins from every party's enable and the pulls
  assign ref_w  = ref_clk_oe ? ref_clk_o : osc;
  assign crs_w  = crs_dv_oe ? crs_dv_o : crs_pull;
  assign rxer_w = rxer_oe ? rxer_o : rxer_pull;
  assign t1_w   = txd1_oe ? txd1_o : txd[1];
  assign irq_w  = irq_open_drain_out_oe ? 1'b0 : 1'b1; // Pull-up on the line

  rmp_phy_side #(.VARIANT_GEN_CLK(1'b1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clock_in(osc), .ref_clk_i(ref_w),
    .ref_clk_o(ref_clk_o), .ref_clk_oe(ref_clk_oe), .txen(txen), .txd0(txd[0]), .txd1_i(t1_w), .txd1_o(txd1_o),
    .txd1_oe(txd1_oe), .crs_dv_i(crs_w), .crs_dv_o(crs_dv_o), .crs_dv_oe(crs_dv_oe), .rxd_o(rxd_o),
    .rxd_oe(rxd_oe), .rxer_i(rxer_w), .rxer_o(rxer_o), .rxer_oe(rxer_oe),
    .irq_open_drain_out_o(irq_open_drain_out_o), .irq_open_drain_out_oe(irq_open_drain_out_oe),
    .rx_vld(rx_vld), .rx_err(rx_err), .rx_dat(rx_dat), .rx_take(rx_take), .tx_vld(tx_vld), .tx_dat(tx_dat),
    .mgmt_addr(mgmt_addr));
  rmp_mac_model mac (.ref_clk(ref_w), .send(send), .dat(mdat), .pull_hi(nand_req), .txen(txen),
    .txd(txd), .rxer_pull(rxer_pull));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bounded wait: 0 receive take, 1 transmit take, 2 bus answer
  task automatic wait_for(input int w);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!((w == 0 && rx_take === 1'b1) || (w == 1 && tx_vld === 1'b1) || (w == 2 && pready === 1'b1))
               && k < 200);
    if (k >= 200) begin
      fail_count++;
      $display("mismatch wait %0d expected answer seen none", w);
      print_verdict();
    end
  endtask : wait_for

  // One APB transfer; idle cycle first so psel never changes twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    wait_for(2);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic count_tx(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (tx_vld === 1'b1) n++;
    end
  endtask : count_tx

  // Straps are held on the pulls across the whole release window
  task automatic do_reset(input logic cs, input logic es);
    presetn  <= 1'b0;
    crs_pull <= cs;
    nand_req <= es;
    repeat (6) @(posedge pclk);
    chk("oe in reset", 32'({crs_dv_oe, rxd_oe, rxer_oe, ref_clk_oe}), 32'h0);
    presetn  <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("oe after reset", 32'({crs_dv_oe, rxd_oe, rxer_oe}), 32'h7);
  endtask : do_reset

  initial begin
    {pclk, osc, presetn, psel, penable, pwrite, send, nand_req, crs_pull, rx_vld, rx_err} = '0;
    {paddr, pwdata, mdat, rx_dat} = '0;
    fail_count  = 0;
    checks_done = 0;
    @(posedge pclk);
    // Both address strap levels
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0], 1'b0);
      chk("mgmt_addr", 32'(mgmt_addr), s ? 32'h3 : 32'h0);
      apb(1'b0, A_STRAP, 32'h0);
      chk("strap reg", rd & 32'hFF, s ? 32'h3 : 32'h0);
    end
    apb(1'b0, A_CLK, 32'h0);
    chk("clock mode default", rd & 32'h80, 32'h80);
    // Generated reference: 400 ns period gives 4 toggles in 16 cycles
    n = 0;
    repeat (16) begin
      rd[0] = ref_clk_o;
      @(posedge pclk);
      if (ref_clk_o !== rd[0]) n++;
    end
    chk("ref toggles", 32'(n), 32'h4);
    // Traffic in both clock modes, every dibit value
    for (int m = 1; m >= 0; m--) begin
      apb(1'b1, A_CLK, m ? 32'h80 : 32'h0);
      repeat (4) @(posedge pclk);
      chk("ref oe", 32'(ref_clk_oe), 32'(m));
      for (int d = 0; d < 4; d++) begin
        rx_vld <= 1'b1;
        rx_dat <= d[1:0];
        rx_err <= d[0];
        send   <= 1'b1;
        mdat   <= 2'(3 - d);
        wait_for(0);
        wait_for(0);
        chk("rx pins", 32'({crs_dv_o, rxer_o, rxd_o}), 32'({1'b1, d[0], d[1:0]}));
        wait_for(1);
        wait_for(1);
        chk("tx_dat", 32'(tx_dat), 32'(3 - d));
      end
      rx_vld <= 1'b0;
      rx_err <= 1'b0;
      send   <= 1'b0;
      wait_for(0);
      wait_for(0);
      chk("rx idle", 32'({crs_dv_o, rxer_o, rxd_o}), 32'h0);
      count_tx(24);
      chk("tx idle", 32'(n), 32'h0);
    end
    // Interrupt: sticky, masked, cleared by writing one
    apb(1'b0, A_STAT, 32'h0);
    chk("irq status", rd, 32'hF);
    chk("irq masked", 32'(irq_w), 32'h1);
    apb(1'b1, A_MASK, 32'h4);
    repeat (3) @(posedge pclk);
    chk("irq pulled", 32'({irq_w, irq_open_drain_out_o}), 32'h0);
    apb(1'b1, A_STAT, 32'h4);
    repeat (3) @(posedge pclk);
    chk("irq released", 32'(irq_w), 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk("irq cleared", rd, 32'hB);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    // Error pin strapped high: test mode until the override bit is set
    do_reset(1'b0, 1'b1);
    chk("tree oe", 32'(txd1_oe), 32'h1);
    apb(1'b0, A_STRAP, 32'h0);
    chk("strap test mode", rd & 32'hC0, 32'hC0);
    send   <= 1'b1;
    mdat   <= 2'h1;
    rx_vld <= 1'b1;
    count_tx(40);
    chk("tx refused", 32'(n), 32'h0);
    // Every other tree input now sits high, so the tree output follows the 400 ns oscillator
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      if (t1_w === 1'b0) n++;
    end
    chk("tree low cycles", 32'(n), 32'h8);
    apb(1'b1, A_RXER, 32'h8000);
    repeat (3) @(posedge pclk);
    chk("tree oe off", 32'(txd1_oe), 32'h0);
    wait_for(1);
    wait_for(1);
    chk("tx restored", 32'(tx_dat), 32'h1);
    print_verdict();
  end
endmodule : tb_rmii_phy_side_interface
